// file: src/lbsi_consts.svh
/*
 constants for the loop, branch and software interrupt execution unit.
 assumes inclusion by bare name from the execution unit file.
*/
`ifndef LBSI_CONSTS_SVH
`define LBSI_CONSTS_SVH
`define LBSI_VEC_OVERFLOW   8'h04
`define LBSI_VEC_RANGE      8'h05
`define LBSI_VEC_INVALID    8'h06
`define LBSI_ITEM_BYTES_64  8'h08
`define LBSI_ITEM_BYTES_32  8'h04
`define LBSI_ITEM_BYTES_16  8'h02
`define LBSI_FLAGS_RESET    64'h0000_0000_0000_0002
`define LBSI_ZERO_FLAG_BIT  6
`define LBSI_OVF_FLAG_BIT   11
`endif

// file: src/lbsi_count_unit.sv
/*
 count register decrement and zero test at the selected address size.
 assumes a purely combinational use from the execution unit.
*/
module lbsi_count_unit
   import lbsi_pkg::*;
(
   input  wire logic [63:0] count_in,
   input  wire lbsi_asz_e   asz,
   input  wire logic        dec_en,
   output logic      [63:0] count_out,
   output logic             zero_before,
   output logic             zero_after
);
   logic [63:0] dec_full;

   // R3 wraps to ones
   assign dec_full = count_in - 64'h1;

   // R12 size selects register
   always_comb begin
      count_out   = count_in;
      zero_before = 1'b0;
      zero_after  = 1'b0;
      case (asz)
         LBSI_ASZ_16: begin
            if (dec_en) count_out = {count_in[63:16], dec_full[15:0]};
            zero_before = (count_in[15:0] == 16'h0);
            zero_after  = (count_out[15:0] == 16'h0);
         end
         LBSI_ASZ_32: begin
            // upper half cleared on a 32-bit register write, as in 64-bit cores
            if (dec_en) count_out = {32'h0, dec_full[31:0]};
            zero_before = (count_in[31:0] == 32'h0);
            zero_after  = (count_out[31:0] == 32'h0);
         end
         default: begin
            if (dec_en) count_out = dec_full;
            zero_before = (count_in == 64'h0);
            zero_after  = (count_out == 64'h0);
         end
      endcase
   end
endmodule

// file: src/lbsi_exec.sv
/*
 execution unit for counted loops, count-empty branches, near branch sizing,
 software interrupts, overflow trap, range check and interrupt return.
 assumes decoded instructions arrive one per cycle on issue_valid, with
 operands and stack words already fetched by the core, all on clk.
*/
`include "lbsi_consts.svh"

// Summary of operation
// R1 - loop decrements count, branches if nonzero
// R2 - zero count after decrement falls through
// R3 - zero count wraps to all ones
// R4 - equal variant needs nonzero count, zero set
// R5 - unequal variant needs nonzero count, zero clear
// R6 - alias names decode to same operation
// R7 - 32-bit empty branch tests count, no decrement
// R8 - 16-bit empty branch tests 16-bit count
// R9 - 64-bit mode near branches use 64 bits
// R10 - 64-bit mode pointer, stack, indirect widths
// R11 - displacement stays 32 bits, address unforced
// R12 - address size picks count register width
// R13 - soft interrupt raises encoded vector
// R14 - interrupt saves flags and return pointer
// R15 - interrupt return pops pointer like exit
// R16 - overflow trap only when flag set
// R17 - range check faults outside bounds
// R18 - 64-bit mode eight-byte items, always pop stack
// R19 - range check invalid in 64-bit mode
// R20 - compat mode pops stack on privilege change
// R21 - interrupt return restores flags word
// R22 - conditional branches relative, never far
// R23 - loops and empty branches keep flags
module lbsi_exec
   import lbsi_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        issue_valid,
   input  wire lbsi_op_e    issue_op,
   input  wire lbsi_mode_e  cpu_mode,
   input  wire logic        addr_override,
   input  wire logic        addr_16,
   input  wire logic        opsize_16,
   input  wire logic [31:0] rel_disp,
   input  wire logic [63:0] next_ip,
   input  wire logic [63:0] ind_target,
   input  wire logic        cond_true,
   input  wire logic [63:0] count_reg_64,
   input  wire logic [63:0] flags_word,
   input  wire logic [63:0] stack_pointer_64,
   input  wire logic [7:0]  vector_in,
   input  wire logic [63:0] pop_ip,
   input  wire logic [63:0] pop_flags,
   input  wire logic [1:0]  pop_privilege,
   input  wire logic [1:0]  current_privilege,
   input  wire logic [63:0] range_value,
   input  wire logic [63:0] range_lower,
   input  wire logic [63:0] range_upper,
   output logic             done_q,
   output logic             branch_taken_q,
   output logic [63:0]      instr_pointer_64_q,
   output logic             count_we_q,
   output logic [63:0]      count_out_q,
   output logic             flags_we_q,
   output logic [63:0]      flags_out_q,
   output logic             raise_q,
   output logic [7:0]       raise_vector_q,
   output logic             push_ip_flags_q,
   output logic             pop_ss_sp_q,
   output logic [7:0]       item_bytes_q,
   output logic [63:0]      stack_pointer_q
);
   lbsi_asz_e   asz;
   logic [63:0] cnt_next;
   logic        cnt_zero_before;
   logic        cnt_zero_after;
   logic        is_loop;
   logic        zero_flag;
   logic        overflow_flag;
   logic        mode64;
   logic        loop_go;
   logic        take;
   logic [63:0] rel_target;
   logic [63:0] target;
   logic [7:0]  item_bytes;
   logic        range_fault;
   logic        raise;
   logic [7:0]  raise_vec;
   logic        pop_ss;
   logic [63:0] sp_after;

   function automatic logic [63:0] lbsi_trunc_ip(input logic [63:0] ip,
                                                 input logic        m64,
                                                 input logic        o16);
      if (m64)
         lbsi_trunc_ip = ip;
      else if (o16)
         lbsi_trunc_ip = {48'h0, ip[15:0]};
      else
         lbsi_trunc_ip = {32'h0, ip[31:0]};
   endfunction

   function automatic logic lbsi_slt(input logic [63:0] a, input logic [63:0] b);
      lbsi_slt = $signed(a) < $signed(b);
   endfunction

   assign mode64 = (cpu_mode == LBSI_MODE_64);
   assign zero_flag     = flags_word[`LBSI_ZERO_FLAG_BIT];
   assign overflow_flag = flags_word[`LBSI_OVF_FLAG_BIT];

   // R12 64-bit mode: default 64, prefix gives 32; else 32, addr_16 gives 16
   assign asz = lbsi_asz_e'(mode64 ? (addr_override ? LBSI_ASZ_32 : LBSI_ASZ_64)
                                   : (addr_16 ? LBSI_ASZ_16 : LBSI_ASZ_32));

   // R6 aliases share one op
   assign is_loop = (issue_op == LBSI_OP_LOOP) || (issue_op == LBSI_OP_LOOP_EQ)
                  || (issue_op == LBSI_OP_LOOP_NE);

   // R1 R3 decrement before test
   lbsi_count_unit u_count (
      .count_in    (count_reg_64),
      .asz         (asz),
      .dec_en      (is_loop),
      .count_out   (cnt_next),
      .zero_before (cnt_zero_before),
      .zero_after  (cnt_zero_after)
   );

   // R2 R4 R5 loop exit terms
   assign loop_go = !cnt_zero_after &&
                    ((issue_op == LBSI_OP_LOOP) ||
                     (issue_op == LBSI_OP_LOOP_EQ && zero_flag) ||
                     (issue_op == LBSI_OP_LOOP_NE && !zero_flag));

   // R7 R8 empty test, no decrement
   // R22 conditional targets stay relative
   always_comb begin
      take = 1'b0;
      case (issue_op)
         LBSI_OP_LOOP, LBSI_OP_LOOP_EQ, LBSI_OP_LOOP_NE: take = loop_go;
         LBSI_OP_JCOUNT_EMPTY: take = cnt_zero_before;
         LBSI_OP_JCC:          take = cond_true;
         LBSI_OP_BRANCH_REL, LBSI_OP_BRANCH_IND, LBSI_OP_CALL_REL,
         LBSI_OP_PROC_EXIT, LBSI_OP_INT_RETURN: take = 1'b1;
         default:              take = 1'b0;
      endcase
   end

   // R11 sign-extended 32-bit displacement
   assign rel_target = next_ip + {{32{rel_disp[31]}}, rel_disp};

   // R9 R10 64-bit pointer in 64-bit mode
   // R15 return pointer popped as exit
   assign target = lbsi_trunc_ip(
      (issue_op == LBSI_OP_BRANCH_IND) ? ind_target :
      ((issue_op == LBSI_OP_PROC_EXIT) || (issue_op == LBSI_OP_INT_RETURN)) ? pop_ip :
      rel_target, mode64, opsize_16);

   // R10 R18 stack item width
   assign item_bytes = mode64 ? `LBSI_ITEM_BYTES_64 :
                       (opsize_16 ? `LBSI_ITEM_BYTES_16 : `LBSI_ITEM_BYTES_32);

   // R17 signed bounds compare
   assign range_fault = lbsi_slt(range_value, range_lower) ||
                        lbsi_slt(range_upper, range_value);

   // R13 R16 R17 R19 exception selection
   always_comb begin
      raise     = 1'b0;
      raise_vec = 8'h00;
      case (issue_op)
         LBSI_OP_SOFT_INT: begin
            raise     = 1'b1;
            raise_vec = vector_in;
         end
         LBSI_OP_TRAP_OVF: begin
            raise     = overflow_flag;
            raise_vec = `LBSI_VEC_OVERFLOW;
         end
         LBSI_OP_RANGE_CHK: begin
            if (mode64) begin
               raise     = 1'b1;
               raise_vec = `LBSI_VEC_INVALID;
            end else begin
               raise     = range_fault;
               raise_vec = `LBSI_VEC_RANGE;
            end
         end
         default: begin
            raise     = 1'b0;
            raise_vec = 8'h00;
         end
      endcase
   end

   // R18 R20 stack segment and pointer pop
   assign pop_ss = (issue_op == LBSI_OP_INT_RETURN) &&
                   (mode64 || (pop_privilege != current_privilege));

   // three items for pointer, segment and flags; two more when ss:sp pops
   assign sp_after = (issue_op == LBSI_OP_CALL_REL) ?
                        stack_pointer_64 - {56'h0, item_bytes} :
                     (issue_op == LBSI_OP_PROC_EXIT) ?
                        stack_pointer_64 + {56'h0, item_bytes} :
                     (issue_op == LBSI_OP_INT_RETURN) ?
                        stack_pointer_64 + ({56'h0, item_bytes} *
                                            (pop_ss ? 64'h5 : 64'h3)) :
                        stack_pointer_64;

   logic        int_return_op;
   logic        done_d;
   logic        branch_taken_d;
   logic [63:0] instr_pointer_64_d;
   logic        count_we_d;
   logic [63:0] count_out_d;
   logic        flags_we_d;
   logic [63:0] flags_out_d;
   logic        raise_d;
   logic [7:0]  raise_vector_d;
   logic        push_ip_flags_d;
   logic        pop_ss_sp_d;
   logic [7:0]  item_bytes_d;
   logic [63:0] stack_pointer_d;

   assign int_return_op = (issue_op == LBSI_OP_INT_RETURN);

   // data outputs follow every cycle; the strobes and the stack pointer update wait for issue_valid
   assign done_d             = issue_valid;
   assign branch_taken_d     = issue_valid && take;
   // not taken still truncates the sequential pointer to the operand size
   assign instr_pointer_64_d = branch_taken_d ? target
                                              : lbsi_trunc_ip(next_ip, mode64, opsize_16);
   assign count_we_d         = issue_valid && is_loop;
   assign count_out_d        = cnt_next;
   // R23 loops never write flags
   // R21 flags restored on return
   assign flags_we_d         = issue_valid && int_return_op;
   assign flags_out_d        = flags_we_d ? pop_flags : flags_word;
   assign raise_d            = issue_valid && raise;
   assign raise_vector_d     = raise_vec;
   // R14 flags and pointer saved
   assign push_ip_flags_d    = raise_d;
   assign pop_ss_sp_d        = issue_valid && pop_ss;
   assign item_bytes_d       = item_bytes;
   assign stack_pointer_d    = issue_valid ? sp_after : stack_pointer_64;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         done_q             <= 1'b0;
         branch_taken_q     <= 1'b0;
         instr_pointer_64_q <= 64'h0;
      end else begin
         done_q             <= done_d;
         branch_taken_q     <= branch_taken_d;
         instr_pointer_64_q <= instr_pointer_64_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         count_we_q  <= 1'b0;
         count_out_q <= 64'h0;
      end else begin
         count_we_q  <= count_we_d;
         count_out_q <= count_out_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         flags_we_q  <= 1'b0;
         flags_out_q <= `LBSI_FLAGS_RESET;
      end else begin
         flags_we_q  <= flags_we_d;
         flags_out_q <= flags_out_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         raise_q         <= 1'b0;
         raise_vector_q  <= 8'h00;
         push_ip_flags_q <= 1'b0;
      end else begin
         raise_q         <= raise_d;
         raise_vector_q  <= raise_vector_d;
         push_ip_flags_q <= push_ip_flags_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         pop_ss_sp_q  <= 1'b0;
         item_bytes_q <= `LBSI_ITEM_BYTES_32;
      end else begin
         pop_ss_sp_q  <= pop_ss_sp_d;
         item_bytes_q <= item_bytes_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         stack_pointer_q <= 64'h0;
      end else begin
         stack_pointer_q <= stack_pointer_d;
      end
   end
endmodule

// file: src/lbsi_pkg.sv
/*
 types shared by the loop, branch and software interrupt unit.
 assumes lbsi_consts.svh is on the include path.
*/
package lbsi_pkg;
   typedef enum logic [3:0] {
      LBSI_OP_NONE,
      LBSI_OP_LOOP,
      LBSI_OP_LOOP_EQ,
      LBSI_OP_LOOP_NE,
      LBSI_OP_JCOUNT_EMPTY,
      LBSI_OP_JCC,
      LBSI_OP_BRANCH_REL,
      LBSI_OP_BRANCH_IND,
      LBSI_OP_CALL_REL,
      LBSI_OP_PROC_EXIT,
      LBSI_OP_SOFT_INT,
      LBSI_OP_TRAP_OVF,
      LBSI_OP_RANGE_CHK,
      LBSI_OP_INT_RETURN
   } lbsi_op_e;

   typedef enum logic [1:0] {
      LBSI_ASZ_16,
      LBSI_ASZ_32,
      LBSI_ASZ_64
   } lbsi_asz_e;

   typedef enum logic [1:0] {
      LBSI_MODE_LEGACY,
      LBSI_MODE_COMPAT,
      LBSI_MODE_64
   } lbsi_mode_e;
endpackage

// file: verification/lbsi_exec_props.sv
/*
 checker for the loop, branch and software interrupt unit.
 assumes a bind onto lbsi_exec, one clock, synchronous reset.
*/
module lbsi_exec_props
   import lbsi_pkg::*;
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        issue_valid,
   input wire lbsi_op_e    issue_op,
   input wire lbsi_mode_e  cpu_mode,
   input wire logic        addr_override,
   input wire logic [63:0] count_reg_64,
   input wire logic [63:0] flags_word,
   input wire logic [7:0]  vector_in,
   input wire logic [63:0] pop_flags,
   input wire logic        done_q,
   input wire logic        count_we_q,
   input wire logic [63:0] count_out_q,
   input wire logic        flags_we_q,
   input wire logic [63:0] flags_out_q,
   input wire logic        raise_q,
   input wire logic [7:0]  raise_vector_q,
   input wire logic        push_ip_flags_q,
   input wire logic        pop_ss_sp_q,
   input wire logic [7:0]  item_bytes_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_op(lbsi_op_e o);
      issue_valid && issue_op == o;
   endsequence
   a_done_follows: assert property (issue_valid |=> done_q)
      else $error("done missing after issue");
   a_done_quiet: assert property (!issue_valid |=> !done_q)
      else $error("done without issue");
   a_soft_raise: assert property (s_op(LBSI_OP_SOFT_INT) |=>
      raise_q && push_ip_flags_q && raise_vector_q == $past(vector_in))
      else $error("soft interrupt not raised");
   a_trap_set: assert property (s_op(LBSI_OP_TRAP_OVF) ##0 flags_word[11] |=>
      raise_q && raise_vector_q == 8'h04) else $error("overflow trap missing");
   a_trap_clear: assert property (s_op(LBSI_OP_TRAP_OVF) ##0 !flags_word[11] |=>
      !raise_q) else $error("overflow trap with flag clear");
   a_range_invalid: assert property (s_op(LBSI_OP_RANGE_CHK) ##0 cpu_mode == LBSI_MODE_64
      |=> raise_q && raise_vector_q == 8'h06) else $error("range check accepted");
   a_loop_flags: assert property (issue_valid && issue_op inside {LBSI_OP_LOOP,
      LBSI_OP_LOOP_EQ, LBSI_OP_LOOP_NE, LBSI_OP_JCOUNT_EMPTY} |=> !flags_we_q)
      else $error("loop wrote flags");
   a_empty_no_dec: assert property (s_op(LBSI_OP_JCOUNT_EMPTY) |=> !count_we_q)
      else $error("empty branch wrote count");
   a_return_flags: assert property (s_op(LBSI_OP_INT_RETURN) |=>
      flags_we_q && flags_out_q == $past(pop_flags)) else $error("flags not restored");
   a_return_pop64: assert property (s_op(LBSI_OP_INT_RETURN) ##0 cpu_mode == LBSI_MODE_64
      |=> pop_ss_sp_q && item_bytes_q == 8'h08) else $error("wide return pop wrong");
   a_loop_dec64: assert property (s_op(LBSI_OP_LOOP) ##0 cpu_mode == LBSI_MODE_64 &&
      !addr_override |=> count_we_q && count_out_q == $past(count_reg_64) - 64'h1)
      else $error("wide count decrement wrong");
endmodule

// file: verification/tb_top.sv
/*
 self-checking bench for the loop, branch and software interrupt unit.
 assumes the bench drives every input itself; no far-side model.
*/
module tb_top
   import lbsi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rstn, issue_valid, addr_override, addr_16, opsize_16, cond_true;
   lbsi_op_e    issue_op;
   lbsi_mode_e  cpu_mode;
   logic [31:0] rel_disp;
   logic [63:0] next_ip, ind_target, count_reg_64, flags_word, stack_pointer_64, pop_ip;
   logic [63:0] pop_flags, range_value, range_lower, range_upper;
   logic [63:0] instr_pointer_64_q, count_out_q, flags_out_q, stack_pointer_q;
   logic [7:0]  vector_in, raise_vector_q, item_bytes_q;
   logic [1:0]  pop_privilege, current_privilege;
   logic        done_q, branch_taken_q, count_we_q, flags_we_q, raise_q, push_ip_flags_q;
   logic        pop_ss_sp_q;
   int          fail_count, n_compared;
   lbsi_op_e    ops [14] = '{LBSI_OP_NONE, LBSI_OP_LOOP, LBSI_OP_LOOP_EQ, LBSI_OP_LOOP_NE,
      LBSI_OP_JCOUNT_EMPTY, LBSI_OP_JCC, LBSI_OP_BRANCH_REL, LBSI_OP_BRANCH_IND,
      LBSI_OP_CALL_REL, LBSI_OP_PROC_EXIT, LBSI_OP_SOFT_INT, LBSI_OP_TRAP_OVF,
      LBSI_OP_RANGE_CHK, LBSI_OP_INT_RETURN};
   lbsi_exec dut_u (.clk, .rstn, .issue_valid, .issue_op, .cpu_mode, .addr_override,
      .addr_16, .opsize_16, .rel_disp, .next_ip, .ind_target, .cond_true, .count_reg_64,
      .flags_word, .stack_pointer_64, .vector_in, .pop_ip, .pop_flags, .pop_privilege,
      .current_privilege, .range_value, .range_lower, .range_upper, .done_q,
      .branch_taken_q, .instr_pointer_64_q, .count_we_q, .count_out_q, .flags_we_q,
      .flags_out_q, .raise_q, .raise_vector_q, .push_ip_flags_q, .pop_ss_sp_q,
      .item_bytes_q, .stack_pointer_q);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // issue one operation, then compare every result with the model
   task automatic one_op(input lbsi_op_e op);
      logic [63:0] msk, cx, opm, tg, ip, sp;
      logic        m64, lp, tk, rs, pp;
      logic [7:0]  vc, ib;
      @(negedge clk);
      issue_valid = 1'b1;
      issue_op = op;
      cpu_mode = lbsi_mode_e'($urandom_range(2));
      {addr_override, addr_16, opsize_16, cond_true, pop_privilege, current_privilege}
         = 8'($urandom);
      {next_ip, rel_disp, flags_word, vector_in} = 168'({$urandom, $urandom, $urandom,
         $urandom, $urandom, $urandom});
      {stack_pointer_64, pop_ip, pop_flags, ind_target} = {$urandom, $urandom, $urandom,
         $urandom, $urandom, $urandom, $urandom, $urandom};
      // shifts bias the count towards zero and small values
      count_reg_64 = {$urandom, $urandom} >> (8 * $urandom_range(8));
      if ($urandom_range(4) == 0) count_reg_64[31:0] = 32'h1;
      // small signed operands agree at every operand width
      range_value = 64'($urandom_range(40)) - 64'd20;
      range_lower = 64'($urandom_range(40)) - 64'd20;
      range_upper = 64'($urandom_range(40)) - 64'd20;
      @(posedge clk);
      #1;
      m64 = cpu_mode == LBSI_MODE_64;
      msk = (m64 && !addr_override) ? '1 : ((!m64 && addr_16) ? 64'hffff : 64'hffff_ffff);
      cx = ((count_reg_64 - 64'h1) & msk) | ((msk == 64'hffff) ? count_reg_64 & ~msk : 64'h0);
      lp = op inside {LBSI_OP_LOOP, LBSI_OP_LOOP_EQ, LBSI_OP_LOOP_NE};
      tk = lp ? ((cx & msk) != 0 && (op == LBSI_OP_LOOP || flags_word[6] ==
         (op == LBSI_OP_LOOP_EQ))) : (op == LBSI_OP_JCOUNT_EMPTY) ?
         ((count_reg_64 & msk) == 0) : (op == LBSI_OP_JCC) ? cond_true :
         (op inside {LBSI_OP_BRANCH_REL, LBSI_OP_BRANCH_IND, LBSI_OP_CALL_REL,
         LBSI_OP_PROC_EXIT, LBSI_OP_INT_RETURN});
      // operand size sets pointer truncation and stack item width
      opm = m64 ? '1 : (opsize_16 ? 64'hffff : 64'hffff_ffff);
      ib = m64 ? 8'h08 : (opsize_16 ? 8'h02 : 8'h04);
      pp = op == LBSI_OP_INT_RETURN && (m64 || pop_privilege != current_privilege);
      tg = (op == LBSI_OP_BRANCH_IND) ? ind_target : (op inside {LBSI_OP_PROC_EXIT,
         LBSI_OP_INT_RETURN}) ? pop_ip : next_ip + 64'($signed(rel_disp));
      ip = (tk ? tg : next_ip) & opm;
      sp = (op == LBSI_OP_CALL_REL) ? stack_pointer_64 - 64'(ib) :
         (op == LBSI_OP_PROC_EXIT) ? stack_pointer_64 + 64'(ib) :
         (op == LBSI_OP_INT_RETURN) ? stack_pointer_64 + 64'(ib) * (pp ? 64'd5 : 64'd3) :
         stack_pointer_64;
      rs = op == LBSI_OP_SOFT_INT || (op == LBSI_OP_TRAP_OVF && flags_word[11]) ||
         (op == LBSI_OP_RANGE_CHK && (m64 || $signed(range_value) < $signed(range_lower)
         || $signed(range_value) > $signed(range_upper)));
      vc = (op == LBSI_OP_SOFT_INT) ? vector_in : ((op == LBSI_OP_TRAP_OVF) ? 8'h04 :
         (m64 ? 8'h06 : 8'h05));
      chk(done_q, 1'b1);
      chk(branch_taken_q, tk);
      chk(count_we_q, lp);
      chk(count_out_q, lp ? cx : count_reg_64);
      chk(flags_we_q, op == LBSI_OP_INT_RETURN);
      chk(instr_pointer_64_q, ip);
      chk(raise_q, rs);
      chk(push_ip_flags_q, rs);
      if (rs) chk(raise_vector_q, vc);
      chk(flags_out_q, (op == LBSI_OP_INT_RETURN) ? pop_flags : flags_word);
      chk(pop_ss_sp_q, pp);
      chk(item_bytes_q, ib);
      chk(stack_pointer_q, sp);
   endtask
   initial begin
      {rstn, issue_valid, addr_override, addr_16, opsize_16, cond_true} = '0;
      issue_op = LBSI_OP_NONE;
      cpu_mode = LBSI_MODE_64;
      {rel_disp, next_ip, ind_target, count_reg_64, flags_word, stack_pointer_64} = '0;
      {pop_ip, pop_flags, vector_in, pop_privilege, current_privilege} = '0;
      {range_value, range_lower, range_upper} = '0;
      void'($urandom(32'h3665));
      repeat (20) @(negedge clk);
      chk(flags_out_q, 64'h2);
      chk(item_bytes_q, 8'h04);
      chk({done_q, raise_q, count_we_q}, 3'h0);
      $display("reset test done");
      rstn = 1'b1;
      repeat (400) one_op(ops[$urandom_range(13)]);
      @(negedge clk);
      issue_valid = 1'b0;
      @(posedge clk);
      #1;
      chk(done_q, 1'b0);
      $display("random operation test done");
      end_of_test;
   end
   // limit well above 420 cycles so only a hang reaches it
   initial begin
      #20000;
      fail_count++;
      end_of_test;
   end
endmodule
bind lbsi_exec lbsi_exec_props u_props (.clk, .rstn, .issue_valid, .issue_op, .cpu_mode,
   .addr_override, .count_reg_64, .flags_word, .vector_in, .pop_flags, .done_q,
   .count_we_q, .count_out_q, .flags_we_q, .flags_out_q, .raise_q, .raise_vector_q,
   .push_ip_flags_q, .pop_ss_sp_q, .item_bytes_q);
